// >>> ctp_peci_readout.sv
`timescale 1ns/1ns
`default_nettype none
module ctp_peci_readout
  import ctp_pkg::*;
#(
  parameter int POLL_CYC    = POLL_TIME_US * 1000 / CLK_PERIOD_NS,
  parameter int NUM_CLIENTS = CLIENT_COUNT
)(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire ctp_reg_req_t reg_req,
  input  wire logic         reg_valid,
  output logic [7:0]        reg_rdata,
  input  wire logic [7:0]   supply_code,
  input  wire logic         supply_valid,
  input  wire logic         peci_in,
  output logic              peci_out,
  output logic              peci_oe,
  output logic              smbalert_n
);

  localparam int CIW = $clog2(NUM_CLIENTS);
  localparam logic [CIW-1:0] LAST_CLIENT = CIW'(NUM_CLIENTS - 1);

  ctp_state_t           state;
  ctp_state_t           next_state;
  logic [7:0]           next_byte;
  logic                 issued;
  logic                 start;
  logic                 rx_mode;
  logic [7:0]           tx_byte;
  logic                 done;
  logic [7:0]           rx_byte;
  logic [CIW-1:0]       client;
  logic                 dom;
  logic [31:0]          poll_cnt;
  logic [7:0]           payload_lo;
  logic [7:0]           cur_red;
  logic [7:0]           best;
  logic [7:0]           hot;
  logic [7:0]           ref_supply;
  logic                 supply_ok;
  logic [7:0]           cfg;
  logic [7:0]           rd_mux;
  logic [7:0]           value [NUM_CLIENTS];
  logic [7:0]           high  [NUM_CLIENTS];
  logic [7:0]           low   [NUM_CLIENTS];
  logic [NUM_CLIENTS-1:0] oor;
  logic [NUM_CLIENTS-1:0] status;
  logic                 wr_en;

  assign wr_en = reg_valid && reg_req.wr;

  // Reference supply sample comes from the converter on this clock.
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_supply <= SUPPLY_RST;
    end else if (supply_valid) begin
      ref_supply <= supply_code;
    end
  end

  assign supply_ok = ref_supply >= SUPPLY_MIN;

  assign hot = (dom && ($signed(best) > $signed(cur_red))) ? best : cur_red;

  // Byte sent by each write step and state that follows each link step.
  always_comb begin
    next_byte  = 8'h00;
    next_state = S_IDLE;
    unique case (state)
      S_ADDR: begin
        next_byte  = CLIENT_BASE + 8'(client);
        next_state = S_WLEN;
      end
      S_WLEN: begin
        next_byte  = WR_LEN;
        next_state = S_RLEN;
      end
      S_RLEN: begin
        next_byte  = RD_LEN;
        next_state = S_CMD;
      end
      S_CMD: begin
        next_byte  = dom ? CMD_DOM1 : CMD_DOM0;
        next_state = S_RDLO;
      end
      S_RDLO: next_state = S_RDHI;
      S_RDHI: next_state = S_STORE;
      S_IDLE, S_STORE: next_state = S_IDLE;
    endcase
  end

  // Poll sequencer: one read per domain, then the hotter one is stored.
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= S_IDLE;
      issued     <= 1'b0;
      start      <= 1'b0;
      rx_mode    <= 1'b0;
      tx_byte    <= 8'h00;
      client     <= '0;
      dom        <= 1'b0;
      poll_cnt   <= 32'h0000_0000;
      payload_lo <= 8'h00;
      cur_red    <= VALUE_RST;
      best       <= VALUE_RST;
      for (int i = 0; i < NUM_CLIENTS; i++) begin
        value[i] <= VALUE_RST;
      end
    end else begin
      start <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (poll_cnt == 32'(POLL_CYC - 1)) begin
            poll_cnt <= 32'h0000_0000;
            if (cfg[CFG_POLL_EN] && supply_ok) begin
              state  <= S_ADDR;
              client <= '0;
              dom    <= 1'b0;
            end
          end else begin
            poll_cnt <= poll_cnt + 32'h0000_0001;
          end
        end
        S_ADDR, S_WLEN, S_RLEN, S_CMD, S_RDLO, S_RDHI: begin
          if (!issued) begin
            start   <= 1'b1;
            issued  <= 1'b1;
            tx_byte <= next_byte;
            rx_mode <= (state == S_RDLO) || (state == S_RDHI);
          end else if (done) begin
            issued <= 1'b0;
            state  <= next_state;
            if (state == S_RDLO) begin
              payload_lo <= rx_byte;
            end
            // keep sign and bits 12 to 6
            if (state == S_RDHI) begin
              cur_red <= {rx_byte[PAY_SIGN-8], rx_byte[PAY_HI-8:0],
                          payload_lo[7:PAY_LO]};
            end
          end
        end
        S_STORE: begin
          if (!dom) begin
            best  <= cur_red;
            dom   <= 1'b1;
            state <= S_ADDR;
          end else begin
            value[client] <= hot;
            dom           <= 1'b0;
            if (client == LAST_CLIENT) begin
              state <= S_IDLE;
            end else begin
              client <= client + 1'b1;
              state  <= S_ADDR;
            end
          end
        end
      endcase
    end
  end

  // Per-reading limits and sticky status, write one to clear.
  for (genvar i = 0; i < NUM_CLIENTS; i++) begin : g_chan
    assign oor[i] = ($signed(value[i]) > $signed(high[i])) ||
                    ($signed(value[i]) <= $signed(low[i]));
    always_ff @(posedge clk) begin
      if (rst) begin
        high[i]   <= HIGH_RST;
        low[i]    <= LOW_RST;
        status[i] <= 1'b0;
      end else begin
        if (wr_en && reg_req.addr == REG_HIGH0 + 8'(i)) begin
          high[i] <= reg_req.wdata;
        end
        if (wr_en && reg_req.addr == REG_LOW0 + 8'(i)) begin
          low[i] <= reg_req.wdata;
        end
        if (oor[i]) begin
          status[i] <= 1'b1;
        end else if (wr_en && reg_req.addr == REG_STATUS &&
                     reg_req.wdata[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  end

  // Configuration register.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= CONFIG_RST;
    end else if (wr_en && reg_req.addr == REG_CONFIG) begin
      cfg <= reg_req.wdata;
    end
  end

  // Read decode; unmapped offsets read as zero.
  always_comb begin
    rd_mux = 8'h00;
    if (reg_req.addr == REG_REF_SUPPLY) rd_mux = ref_supply;
    if (reg_req.addr == REG_STATUS) rd_mux = 8'(status);
    if (reg_req.addr == REG_CONFIG) rd_mux = cfg;
    for (int i = 0; i < NUM_CLIENTS; i++) begin
      if (reg_req.addr == REG_VALUE0 + 8'(i)) rd_mux = value[i];
      if (reg_req.addr == REG_HIGH0 + 8'(i)) rd_mux = high[i];
      if (reg_req.addr == REG_LOW0 + 8'(i)) rd_mux = low[i];
    end
  end

  // Registered read data and alert output.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      smbalert_n <= 1'b1;
    end else begin
      reg_rdata  <= rd_mux;
      smbalert_n <= !(cfg[CFG_ALERT_EN] && (|status));
    end
  end

  ctp_bit_engine #(
    .CYC (BIT_CYC)
  ) u_bits (
    .clk     (clk),
    .rst     (rst),
    .start   (start),
    .rx_mode (rx_mode),
    .tx_byte (tx_byte),
    .pin_in  (peci_in),
    .done    (done),
    .rx_byte (rx_byte),
    .pin_out (peci_out),
    .pin_oe  (peci_oe)
  );

  // Checks kept next to the logic they guard.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_poll_start;
    (state == S_IDLE) ##1 (state == S_ADDR);
  endsequence

  sequence s_high_byte_done;
    (state == S_RDHI) && issued && done;
  endsequence

  AST_IDLE_QUIET: assert property (
    (state == S_IDLE) |-> !peci_oe)
    else $error("Link driven while sequencer idle.");

  AST_POLL_OPENS: assert property (
    s_poll_start |=> start && tx_byte == CLIENT_BASE)
    else $error("Poll did not open with first client address.");

  AST_STORE_SLOT: assert property (
    (state == S_STORE) && dom |=> value[$past(client)] == $past(hot))
    else $error("Hotter value not stored in client slot.");

  AST_HOTTER: assert property (
    dom |-> $signed(hot) >= $signed(best) && $signed(hot) >= $signed(cur_red))
    else $error("Stored domain is not the hotter one.");

  AST_FIELD_KEEP: assert property (
    s_high_byte_done |=> cur_red[6:0] == {$past(rx_byte[4:0]),
                                          payload_lo[7:6]})
    else $error("Kept payload bits are wrong.");

  AST_NO_CHANGE: assert property (
    (state != S_STORE) |=> $stable(value[0]))
    else $error("Value changed outside a store.");

  AST_SUPPLY_GATE: assert property (
    (state == S_IDLE) && !supply_ok |=> state == S_IDLE)
    else $error("Poll started without reference supply.");

  AST_SUPPLY_READ: assert property (
    (reg_req.addr == REG_REF_SUPPLY) |=> reg_rdata == $past(ref_supply))
    else $error("Supply register read back wrong.");

  AST_LIMIT_FLAG: assert property (
    oor[0] |=> status[0])
    else $error("Out-of-limit reading did not set status.");

  AST_ALERT: assert property (
    cfg[CFG_ALERT_EN] && (|status) |=> !smbalert_n)
    else $error("Alert not asserted for pending status.");

  AST_SIGN_TOP: assert property (
    s_high_byte_done |=> cur_red[7] == $past(rx_byte[7]))
    else $error("Sign bit not in bit 7.");

endmodule
`default_nettype wire

// >>> ctp_pkg.sv
`default_nettype none
package ctp_pkg;

  // Clock and link timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_TIME_NS   = 2000;
  localparam int BIT_CYC       = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int POLL_TIME_US  = 1000;

  // Client addressing and transaction bytes.
  localparam int         CLIENT_COUNT = 4;
  localparam logic [7:0] CLIENT_BASE  = 8'h30;
  localparam logic [7:0] WR_LEN       = 8'h01;
  localparam logic [7:0] RD_LEN       = 8'h02;
  localparam logic [7:0] CMD_DOM0     = 8'h01;
  localparam logic [7:0] CMD_DOM1     = 8'h02;

  // Thermal payload field positions.
  localparam int PAY_SIGN = 15;
  localparam int PAY_HI   = 12;
  localparam int PAY_LO   = 6;

  // Register offsets.
  localparam logic [7:0] REG_REF_SUPPLY = 8'h1E;
  localparam logic [7:0] REG_VALUE0     = 8'h20;
  localparam logic [7:0] REG_HIGH0      = 8'h24;
  localparam logic [7:0] REG_LOW0       = 8'h28;
  localparam logic [7:0] REG_STATUS     = 8'h2C;
  localparam logic [7:0] REG_CONFIG     = 8'h2D;

  // Configuration fields.
  localparam int CFG_POLL_EN  = 0;
  localparam int CFG_ALERT_EN = 1;

  // Reset values and supply threshold.
  localparam logic [7:0] VALUE_RST  = 8'h80;
  localparam logic [7:0] HIGH_RST   = 8'h00;
  localparam logic [7:0] LOW_RST    = 8'h80;
  localparam logic [7:0] CONFIG_RST = 8'h03;
  localparam logic [7:0] SUPPLY_RST = 8'h00;
  localparam logic [7:0] SUPPLY_MIN = 8'h40;

  // One register access from the management bus engine.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ctp_reg_req_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_WLEN  = 3'b010,
    S_RLEN  = 3'b011,
    S_CMD   = 3'b100,
    S_RDLO  = 3'b101,
    S_RDHI  = 3'b110,
    S_STORE = 3'b111
  } ctp_state_t;

endpackage
`default_nettype wire

// >>> ctp_bit_engine.sv
`timescale 1ns/1ns
`default_nettype none
module ctp_bit_engine
  import ctp_pkg::*;
#(
  parameter int CYC = BIT_CYC
)(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic       rx_mode,
  input  wire logic [7:0] tx_byte,
  input  wire logic       pin_in,
  output logic            done,
  output logic [7:0]      rx_byte,
  output logic            pin_out,
  output logic            pin_oe
);

  localparam logic [7:0] QTR  = 8'(CYC / 4 - 1);
  localparam logic [7:0] HALF = 8'(CYC / 2 - 1);
  localparam logic [7:0] TQTR = 8'(CYC * 3 / 4 - 1);
  localparam logic [7:0] LAST = 8'(CYC - 1);

  logic       pin_meta;
  logic       pin_sync;
  logic       busy;
  logic       mode;
  logic [7:0] cyc;
  logic [2:0] bit_idx;
  logic [7:0] shreg;

  // Two-stage synchroniser for the shared wire.
  always_ff @(posedge clk) begin
    pin_meta <= pin_in;
    pin_sync <= pin_meta;
  end

  assign rx_byte = shreg;

  // Bit timing: every bit opens with a driven high phase; a zero falls
  // at one quarter, a one at three quarters. On receive the wire is
  // released after the quarter and sampled at the half.
  always_ff @(posedge clk) begin
    if (rst) begin
      busy    <= 1'b0;
      mode    <= 1'b0;
      cyc     <= 8'h00;
      bit_idx <= 3'h0;
      shreg   <= 8'h00;
      done    <= 1'b0;
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy    <= 1'b1;
          mode    <= rx_mode;
          cyc     <= 8'h00;
          bit_idx <= 3'h7;
          shreg   <= tx_byte;
          pin_out <= 1'b1;
          pin_oe  <= 1'b1;
        end
      end else begin
        cyc <= cyc + 8'h01;
        if (cyc == QTR) begin
          if (mode) begin
            pin_oe <= 1'b0;
          end else if (!shreg[7]) begin
            pin_out <= 1'b0;
          end
        end
        if (cyc == HALF && mode) begin
          shreg <= {shreg[6:0], pin_sync};
        end
        if (cyc == TQTR && !mode) begin
          pin_out <= 1'b0;
        end
        if (cyc == LAST) begin
          cyc <= 8'h00;
          if (bit_idx == 3'h0) begin
            busy    <= 1'b0;
            done    <= 1'b1;
            pin_oe  <= 1'b0;
            pin_out <= 1'b0;
          end else begin
            bit_idx <= bit_idx - 3'h1;
            pin_out <= 1'b1;
            pin_oe  <= 1'b1;
            if (!mode) begin
              shreg <= {shreg[6:0], 1'b0};
            end
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// >>> ctp_client_model.sv
`timescale 1ns/1ns
`default_nettype none
module ctp_client_model
  import ctp_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             peci_out,
  input  wire logic             peci_oe,
  input  wire logic [7:0][15:0] pay,
  output logic                  cl_oe,
  output logic                  cl_bit,
  output logic                  txn_done,
  output logic [31:0]           txn_word
);
  logic [31:0] sh;
  logic [2:0]  idx;
  int          i;
  int          pos;

  // Each bit starts when the originator raises the wire; the client only
  // answers a read bit once the originator has let go of the wire.
  initial begin
    cl_oe    = 1'b0;
    cl_bit   = 1'b0;
    txn_done = 1'b0;
    txn_word = 32'h0;
    forever begin
      sh = 32'h0;
      for (i = 0; i < 48; i++) begin
        do @(posedge clk); while (peci_oe !== 1'b1 || peci_out !== 1'b1);
        repeat (60) @(posedge clk);
        if (peci_oe === 1'b0 && i >= 32) begin
          idx = {sh[25:24], sh[1]};
          pos = (i < 40) ? 39 - i : 55 - i;
          cl_bit <= pay[idx][pos];
          cl_oe  <= 1'b1;
          repeat (80) @(posedge clk);
          cl_oe  <= 1'b0;
          cl_bit <= 1'b0;
        end else begin
          repeat (40) @(posedge clk);
          sh = {sh[30:0], peci_out};
          do @(posedge clk); while (peci_oe === 1'b1 && peci_out === 1'b1);
        end
      end
      txn_word <= sh;
      txn_done <= 1'b1;
      @(posedge clk);
      txn_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
  import ctp_pkg::*;
;
  localparam int PC = 2000;
  logic             clk;
  logic             rst;
  ctp_reg_req_t     reg_req;
  logic             reg_valid;
  logic [7:0]       reg_rdata;
  logic [7:0]       supply_code;
  logic             supply_valid;
  logic             peci_in;
  logic             peci_out;
  logic             peci_oe;
  logic             smbalert_n;
  logic             cl_oe;
  logic             cl_bit;
  logic             txn_done;
  logic [31:0]      txn_word;
  logic [7:0][15:0] pay;
  logic [7:0]       val [4];
  logic [7:0]       hi;
  logic [7:0]       lo;
  logic [3:0]       st;
  logic [31:0]      seed;
  logic             rd_s;
  logic             rd_d;
  logic [31:0]      eq [$];
  logic [31:0]      tq [$];
  string            nq [$];
  int               errors;
  int               check_count;
  int               txn_cnt;
  int               g;

  // The link wire sits low whenever nobody drives it.
  assign peci_in = peci_oe ? peci_out : (cl_oe ? cl_bit : 1'b0);

  ctp_peci_readout #(.POLL_CYC(PC)) DUT (
    .clk(clk), .rst(rst), .reg_req(reg_req), .reg_valid(reg_valid),
    .reg_rdata(reg_rdata), .supply_code(supply_code),
    .supply_valid(supply_valid), .peci_in(peci_in), .peci_out(peci_out),
    .peci_oe(peci_oe), .smbalert_n(smbalert_n));

  ctp_client_model client (
    .clk(clk), .peci_out(peci_out), .peci_oe(peci_oe), .pay(pay),
    .cl_oe(cl_oe), .cl_bit(cl_bit), .txn_done(txn_done),
    .txn_word(txn_word));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [7:0] keep(input logic [15:0] p);
    return {p[PAY_SIGN], p[PAY_HI:PAY_LO]};
  endfunction

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req   <= '{wr: 1'b1, addr: a, wdata: d};
    reg_valid <= 1'b1;
    @(posedge clk);
    reg_valid <= 1'b0;
    reg_req   <= '{wr: 1'b0, addr: a, wdata: d};
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string nm);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
    rd_s    <= 1'b1;
    eq.push_back({24'h0, e});
    nq.push_back(nm);
    @(posedge clk);
    rd_s <= 1'b0;
  endtask

  task automatic sup(input logic [7:0] c);
    @(posedge clk);
    supply_code  <= c;
    supply_valid <= 1'b1;
    @(posedge clk);
    supply_valid <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares each read result and each link transaction with the oldest note.
  always @(posedge clk) begin
    rd_d <= rd_s;
    if (rd_d === 1'b1) begin
      check(nq.pop_front(), eq.pop_front(), {24'h0, reg_rdata});
    end
    if (txn_done === 1'b1) begin
      txn_cnt++;
      check("link bytes", tq.pop_front(), txn_word);
    end
  end

  // Main sequence: reset, register map, supply gate, poll, limits.
  initial begin
    rst          = 1'b1;
    reg_req      = '0;
    reg_valid    = 1'b0;
    supply_code  = 8'h00;
    supply_valid = 1'b0;
    rd_s         = 1'b0;
    errors       = 0;
    check_count  = 0;
    txn_cnt      = 0;
    seed         = 32'd83;
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      pay[k] = {{4{seed[12]}}, seed[11:0]};
    end
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(REG_REF_SUPPLY, SUPPLY_RST, "supply");
    rd(REG_VALUE0, VALUE_RST, "value0");
    rd(REG_HIGH0, HIGH_RST, "high0");
    rd(REG_LOW0, LOW_RST, "low0");
    rd(REG_CONFIG, CONFIG_RST, "config");
    rd(8'h10, 8'h00, "unmapped");
    rd(REG_STATUS, 8'h0F, "status at reset");
    check("alert at reset", 32'h0, {31'h0, smbalert_n});
    wr(REG_REF_SUPPLY, 8'h55);
    wr(REG_VALUE0, 8'h55);
    rd(REG_REF_SUPPLY, SUPPLY_RST, "supply ro");
    rd(REG_VALUE0, VALUE_RST, "value ro");
    $display("test reset and read-only done");
    sup(SUPPLY_MIN - 8'h01);
    rd(REG_REF_SUPPLY, SUPPLY_MIN - 8'h01, "supply low");
    repeat (3 * PC) @(posedge clk);
    check("polls without supply", 32'h0, txn_cnt);
    $display("test low supply done");
    for (int n = 0; n < 8; n++) begin
      tq.push_back({CLIENT_BASE + 8'(n / 2), WR_LEN, RD_LEN,
                    (n % 2 == 1) ? CMD_DOM1 : CMD_DOM0});
    end
    sup(SUPPLY_MIN);
    g = 0;
    while (txn_cnt < 8 && g < 85000) begin
      @(posedge clk);
      g++;
    end
    if (g == 85000) begin
      errors++;
      tally_and_finish();
    end
    // The last slot is stored only after the final received bit ends.
    repeat (300) @(posedge clk);
    wr(REG_CONFIG, 8'h02);
    for (int n = 0; n < 4; n++) begin
      hi = keep(pay[2 * n]);
      lo = keep(pay[2 * n + 1]);
      val[n] = ($signed(hi) > $signed(lo)) ? hi : lo;
      rd(REG_VALUE0 + 8'(n), val[n], "value");
    end
    $display("test poll done");
    st = 4'h0;
    for (int n = 0; n < 4; n++) begin
      hi = (n % 2 == 1) ? val[n] - 8'h01 : val[n];
      lo = (n == 2) ? val[n] : val[n] - 8'h01;
      wr(REG_HIGH0 + 8'(n), hi);
      wr(REG_LOW0 + 8'(n), lo);
      st[n] = ($signed(val[n]) > $signed(hi)) ||
              ($signed(val[n]) <= $signed(lo));
    end
    wr(REG_STATUS, 8'h0F);
    rd(REG_STATUS, {4'h0, st}, "status");
    repeat (3) @(posedge clk);
    check("alert level", {31'h0, ~|st}, {31'h0, smbalert_n});
    wr(REG_CONFIG, 8'h00);
    repeat (3) @(posedge clk);
    check("alert masked", 32'h1, {31'h0, smbalert_n});
    // With polling switched off no new transaction may open.
    repeat (PC + 100) @(posedge clk);
    check("polls while disabled", 32'h8, txn_cnt);
    $display("test limits done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
